// [egress_pace_vlan_drop_regs.sv]
// AXI4-Lite register bank with egress byte pacers, default tags and ingress drop counters
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none

module egress_pace_vlan_drop_regs
(
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_n_i,
  input  wire logic                                  ce_i,
  // AXI4-Lite slave
  input  wire logic [egress_pace_pkg::ADDR_W-1:0]    s_axi_awaddr_i,
  input  wire logic                                  s_axi_awvalid_i,
  output logic                                       s_axi_awready_o,
  input  wire logic [31:0]                           s_axi_wdata_i,
  input  wire logic [3:0]                            s_axi_wstrb_i,
  input  wire logic                                  s_axi_wvalid_i,
  output logic                                       s_axi_wready_o,
  output logic [1:0]                                 s_axi_bresp_o,
  output logic                                       s_axi_bvalid_o,
  input  wire logic                                  s_axi_bready_i,
  input  wire logic [egress_pace_pkg::ADDR_W-1:0]    s_axi_araddr_i,
  input  wire logic                                  s_axi_arvalid_i,
  output logic                                       s_axi_arready_o,
  output logic [31:0]                                s_axi_rdata_o,
  output logic [1:0]                                 s_axi_rresp_o,
  output logic                                       s_axi_rvalid_o,
  input  wire logic                                  s_axi_rready_i,
  // pacing
  input  wire logic                                  pace_global_en_i,
  input  wire logic [egress_pace_pkg::NUM_QUEUES-1:0] byte_sent_i,
  output logic [egress_pace_pkg::NUM_QUEUES-1:0]     byte_allow_o,
  // default tags and drop events
  output egress_pace_pkg::port_tag_s [egress_pace_pkg::NUM_PORTS-1:0] port_tag_o,
  input  wire logic [egress_pace_pkg::NUM_PORTS-1:0] ingress_drop_i
);

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  // maps a byte address to a bank slot, or SLOT_NONE when unmapped
  function automatic logic [3:0] reg_slot(input logic [egress_pace_pkg::ADDR_W-1:0] addr);
    logic [13:0] idx;
    logic [13:0] rel;
    idx = addr[egress_pace_pkg::ADDR_W-1:2];
    rel = idx - egress_pace_pkg::IDX_PACE_P0_Q01;
    if (idx >= egress_pace_pkg::IDX_PACE_P0_Q01 && idx <= egress_pace_pkg::IDX_DROP_P2)
      reg_slot = rel[3:0];
    else
      reg_slot = egress_pace_pkg::SLOT_NONE;
  endfunction

  // expands byte strobes into a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // storage

  logic [31:0]                      pace_reg [egress_pace_pkg::NUM_PACE];
  logic [31:0]                      tag_reg  [egress_pace_pkg::NUM_PORTS];
  logic [31:0]                      drop_reg [egress_pace_pkg::NUM_PORTS];
  logic [31:0]                      reg_word [egress_pace_pkg::NUM_SLOTS];

  ////////////////////////////////////////////////////////////////////////////////
  // write channel

  logic                             aw_hold_reg;
  logic [egress_pace_pkg::ADDR_W-1:0] aw_addr_reg;
  logic                             w_hold_reg;
  logic [31:0]                      w_data_reg;
  logic [3:0]                       w_strb_reg;
  logic                             bvalid_reg;
  logic [1:0]                       bresp_reg;
  wire logic                        aw_fire;
  wire logic                        w_fire;
  wire logic                        wr_fire;
  wire logic [3:0]                  wr_slot;
  wire logic [31:0]                 wr_mask;

  // address and data are taken independently; each stalls until the write is answered
  assign s_axi_awready_o = ce_i & ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready_o  = ce_i & ~w_hold_reg & ~bvalid_reg;
  assign aw_fire         = s_axi_awvalid_i & s_axi_awready_o;
  assign w_fire          = s_axi_wvalid_i & s_axi_wready_o;
  assign wr_fire         = ce_i & aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign wr_slot         = reg_slot(aw_addr_reg);
  assign wr_mask         = strb_mask(w_strb_reg);
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;

  // capture address and data, then commit and raise the response
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= egress_pace_pkg::RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (aw_fire)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (w_fire)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (wr_fire)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (wr_slot == egress_pace_pkg::SLOT_NONE) ?
                       egress_pace_pkg::RESP_SLVERR : egress_pace_pkg::RESP_OKAY;
      end
      else if (bvalid_reg && s_axi_bready_i)
        bvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read channel

  logic                             rvalid_reg;
  logic [31:0]                      rdata_reg;
  logic [1:0]                       rresp_reg;
  wire logic                        ar_fire;
  wire logic [3:0]                  rd_slot;
  wire logic                        rd_mapped;
  wire logic [31:0]                 rd_word;

  // one read in flight; the word is sampled at the address handshake
  assign s_axi_arready_o = ce_i & ~rvalid_reg;
  assign ar_fire         = s_axi_arvalid_i & s_axi_arready_o;
  assign rd_slot         = reg_slot(s_axi_araddr_i);
  assign rd_mapped       = (rd_slot != egress_pace_pkg::SLOT_NONE);
  assign rd_word         = rd_mapped ? reg_word[rd_slot] : 32'h0000_0000;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;

  // hold the answer until the master takes it
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= egress_pace_pkg::RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (ar_fire)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_word;
        rresp_reg  <= rd_mapped ? egress_pace_pkg::RESP_OKAY : egress_pace_pkg::RESP_SLVERR;
      end
      else if (rvalid_reg && s_axi_rready_i)
        rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pacing field registers

  genvar r;
  generate
    for (r = 0; r < egress_pace_pkg::NUM_PACE; r++)
    begin : g_pace_reg
      wire logic        hit;
      wire logic [31:0] merged;

      // reserved bits 31:26 are never stored, so they read as zero
      assign hit    = wr_fire && (wr_slot == egress_pace_pkg::SLOT_PACE0 + 4'(r));
      assign merged = ((pace_reg[r] & ~wr_mask) | (w_data_reg & wr_mask))
                      & egress_pace_pkg::PACE_MASK;
      assign reg_word[egress_pace_pkg::SLOT_PACE0 + r] = pace_reg[r];

      always_ff @(posedge clk_i)
      begin
        if (!rst_n_i)
          pace_reg[r] <= egress_pace_pkg::PACE_RESET;
        else if (ce_i && hit)
          pace_reg[r] <= merged;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // per-queue byte pacers

  genvar q;
  generate
    for (q = 0; q < egress_pace_pkg::NUM_QUEUES; q++)
    begin : g_pacer
      localparam int LSB = (q % 2 == 1) ? egress_pace_pkg::PACE_ODD_LSB
                                        : egress_pace_pkg::PACE_EVEN_LSB;
      logic [egress_pace_pkg::PACE_CNT_W-1:0] gap_reg;
      wire logic [egress_pace_pkg::PACE_W-1:0]     field;
      wire logic [egress_pace_pkg::PACE_CNT_W-1:0] load;
      wire logic                                   take;

      // interval in cycles is (field + 1) * unit; load one less because the
      // send cycle itself counts toward the gap
      assign field = pace_reg[q / 2][LSB +: egress_pace_pkg::PACE_W];
      assign load  = egress_pace_pkg::PACE_CNT_W'(
                       (egress_pace_pkg::PACE_CNT_W'(field) + 15'h0001)
                       * egress_pace_pkg::PACE_CNT_W'(egress_pace_pkg::PACE_UNIT_CYC))
                     - 15'h0001;
      // with the global enable off the queue runs unpaced
      assign byte_allow_o[q] = ~pace_global_en_i | (gap_reg == '0);
      assign take  = byte_sent_i[q] & byte_allow_o[q] & pace_global_en_i;

      always_ff @(posedge clk_i)
      begin
        if (!rst_n_i)
          gap_reg <= '0;
        else if (ce_i)
        begin
          if (!pace_global_en_i)
            gap_reg <= '0;
          else if (take)
            gap_reg <= load;
          else if (gap_reg != '0)
            gap_reg <= gap_reg - 15'h0001;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // per-port default tag and drop counter

  genvar p;
  generate
    for (p = 0; p < egress_pace_pkg::NUM_PORTS; p++)
    begin : g_port
      wire logic        tag_hit;
      wire logic [31:0] tag_merged;
      wire logic        rd_clear;
      wire logic        at_max;

      assign tag_hit    = wr_fire && (wr_slot == egress_pace_pkg::SLOT_TAG0 + 4'(p));
      assign tag_merged = ((tag_reg[p] & ~wr_mask) | (w_data_reg & wr_mask))
                          & egress_pace_pkg::TAG_MASK;
      assign reg_word[egress_pace_pkg::SLOT_TAG0 + p] = tag_reg[p];
      // tag fields go straight to the egress tagger from flops
      assign port_tag_o[p].pri =
        tag_reg[p][egress_pace_pkg::PRI_LSB +: egress_pace_pkg::PRI_W];
      assign port_tag_o[p].vid =
        tag_reg[p][egress_pace_pkg::VID_LSB +: egress_pace_pkg::VID_W];

      // default priority and VLAN ID, reserved bits 31:15 read zero
      always_ff @(posedge clk_i)
      begin
        if (!rst_n_i)
          tag_reg[p] <= egress_pace_pkg::TAG_RESET;
        else if (ce_i && tag_hit)
          tag_reg[p] <= tag_merged;
      end

      // clear happens at the address handshake, the same edge that samples the word
      assign rd_clear = ar_fire && (rd_slot == egress_pace_pkg::SLOT_DROP0 + 4'(p));
      assign at_max   = (drop_reg[p] == egress_pace_pkg::DROP_MAX);
      assign reg_word[egress_pace_pkg::SLOT_DROP0 + p] = drop_reg[p];

      // a drop landing on the clearing read is kept rather than lost
      always_ff @(posedge clk_i)
      begin
        if (!rst_n_i)
          drop_reg[p] <= egress_pace_pkg::DROP_RESET;
        else if (ce_i)
        begin
          if (rd_clear)
            drop_reg[p] <= ingress_drop_i[p] ? 32'h0000_0001 : 32'h0000_0000;
          else if (ingress_drop_i[p] && !at_max)
            drop_reg[p] <= drop_reg[p] + 32'h0000_0001;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// [egress_pace_pkg.sv]
// constants, register map and types for the egress pacing, default tag and drop count bank
`default_nettype none
package egress_pace_pkg;

  // Overview of operation
  // - each queue may send one byte per (field plus one) times 20 ns
  // - 13-bit pace field per queue: odd queue bits 25:13, even 12:0, reset zero
  // - pacing acts only when the global buffer manager pacing enable is set
  // - per port 3-bit default priority in bits 14:12, reset zero, for egress tags
  // - per port 12-bit default VLAN ID in bits 11:0, reset one, for egress tags
  // - per port 32-bit counter counts packets dropped by ingress rate limiting
  // - a software read clears the drop counter; counter resets to zero
  // - drop counter stops at all ones and never wraps

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_PACE_P0_Q01 = 14'h1C0D;
  localparam logic [13:0] IDX_PACE_P0_Q23 = 14'h1C0E;
  localparam logic [13:0] IDX_PACE_P1_Q01 = 14'h1C0F;
  localparam logic [13:0] IDX_PACE_P1_Q23 = 14'h1C10;
  localparam logic [13:0] IDX_PACE_P2_Q01 = 14'h1C11;
  localparam logic [13:0] IDX_PACE_P2_Q23 = 14'h1C12;
  localparam logic [13:0] IDX_TAG_P0      = 14'h1C13;
  localparam logic [13:0] IDX_TAG_P1      = 14'h1C14;
  localparam logic [13:0] IDX_TAG_P2      = 14'h1C15;
  localparam logic [13:0] IDX_DROP_P0     = 14'h1C16;
  localparam logic [13:0] IDX_DROP_P1     = 14'h1C17;
  localparam logic [13:0] IDX_DROP_P2     = 14'h1C18;

  // slot numbering inside the bank: 0..5 pace, 6..8 tag, 9..11 drop
  localparam logic [3:0]  SLOT_PACE0 = 4'h0;
  localparam logic [3:0]  SLOT_TAG0  = 4'h6;
  localparam logic [3:0]  SLOT_DROP0 = 4'h9;
  localparam logic [3:0]  SLOT_NONE  = 4'hF;
  localparam int          NUM_SLOTS  = 12;
  localparam int          NUM_PORTS  = 3;
  localparam int          NUM_QUEUES = 12;
  localparam int          NUM_PACE   = 6;
  localparam int          ADDR_W     = 16;

  // field layout
  localparam int          PACE_W       = 13;
  localparam int          PACE_EVEN_LSB = 0;
  localparam int          PACE_ODD_LSB = 13;
  localparam logic [31:0] PACE_MASK    = 32'h03FF_FFFF;
  localparam int          VID_W        = 12;
  localparam int          VID_LSB      = 0;
  localparam int          PRI_W        = 3;
  localparam int          PRI_LSB      = 12;
  localparam logic [31:0] TAG_MASK     = 32'h0000_7FFF;

  // reset values
  localparam logic [31:0] PACE_RESET = 32'h0000_0000;
  localparam logic [31:0] TAG_RESET  = 32'h0000_0001;
  localparam logic [31:0] DROP_RESET = 32'h0000_0000;
  localparam logic [31:0] DROP_MAX   = 32'hFFFF_FFFF;

  // timing: one pacing unit, converted to clock cycles
  localparam int          PACE_UNIT_NS  = 20;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          PACE_UNIT_CYC = PACE_UNIT_NS / CLK_PERIOD_NS;
  localparam int          PACE_CNT_W    = 15;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [PRI_W-1:0] pri;
    logic [VID_W-1:0] vid;
  } port_tag_s;

endpackage
`default_nettype wire

// [egress_pace_vlan_drop_regs_properties.sv]
// port assertions for the pacing, default tag and drop count bank
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module egress_pace_vlan_drop_regs_properties
(
  input wire logic                             clk_i,
  input wire logic                             rst_n_i,
  input wire logic                             s_axi_awvalid_i,
  input wire logic                             s_axi_awready_o,
  input wire logic                             s_axi_wvalid_i,
  input wire logic                             s_axi_wready_o,
  input wire logic                             s_axi_bvalid_o,
  input wire logic                             s_axi_bready_i,
  input wire logic                             s_axi_arvalid_i,
  input wire logic                             s_axi_arready_o,
  input wire logic [31:0]                      s_axi_rdata_o,
  input wire logic                             s_axi_rvalid_o,
  input wire logic                             s_axi_rready_i,
  input wire logic                             pace_global_en_i,
  input wire logic [11:0]                      byte_sent_i,
  input wire logic [11:0]                      byte_allow_o,
  input wire egress_pace_pkg::port_tag_s [2:0] port_tag_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // bus handshakes; both write halves are offered together by the master
  sequence wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  a_write_resp: assert property (wr_taken |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response missing");
  a_read_resp: assert property (rd_taken |=> s_axi_rvalid_o)
    else $error("read data missing");
  a_resp_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response withdrawn");
  a_data_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data withdrawn");
  a_busy_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken during response");
  a_read_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken during data");
  // pacing only acts with the global enable; a taken byte closes its queue
  a_global_off: assert property (!pace_global_en_i |-> byte_allow_o == 12'hFFF)
    else $error("pacing active while disabled");
  a_pace_gap: assert property (pace_global_en_i && |(byte_sent_i & byte_allow_o) ##1
    pace_global_en_i |-> (byte_allow_o & $past(byte_sent_i & byte_allow_o)) == 12'h000)
    else $error("queue open right after a byte");
  // tags leave reset as priority 0, VLAN 1, and change only on a write commit
  a_tag_reset: assert property ($rose(rst_n_i) |-> port_tag_o == {3{15'h0001}})
    else $error("tag reset value wrong");
  a_tag_on_write: assert property ($changed(port_tag_o) |-> $rose(s_axi_bvalid_o))
    else $error("tag changed without a write");
endmodule

bind egress_pace_vlan_drop_regs egress_pace_vlan_drop_regs_properties i_props
(
  .clk_i, .rst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .pace_global_en_i, .byte_sent_i, .byte_allow_o,
  .port_tag_o
);
`default_nettype wire

// [egress_pace_vlan_drop_regs_tb.sv]
// self-checking bench for the pacing, default tag and drop count bank
`timescale 1ns/1ps
`default_nettype none
module egress_pace_vlan_drop_regs_tb;
  localparam logic [1:0] OK  = egress_pace_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = egress_pace_pkg::RESP_SLVERR;
  localparam int         CYC = egress_pace_pkg::PACE_UNIT_CYC;
  logic        clk_i;
  logic        rst_n_i;
  logic        ce_i;
  logic [15:0] s_axi_awaddr_i;
  logic        s_axi_awvalid_i;
  logic        s_axi_awready_o;
  logic [31:0] s_axi_wdata_i;
  logic [3:0]  s_axi_wstrb_i;
  logic        s_axi_wvalid_i;
  logic        s_axi_wready_o;
  logic [1:0]  s_axi_bresp_o;
  logic        s_axi_bvalid_o;
  logic        s_axi_bready_i;
  logic [15:0] s_axi_araddr_i;
  logic        s_axi_arvalid_i;
  logic        s_axi_arready_o;
  logic [31:0] s_axi_rdata_o;
  logic [1:0]  s_axi_rresp_o;
  logic        s_axi_rvalid_o;
  logic        s_axi_rready_i;
  logic        pace_global_en_i;
  logic [11:0] byte_sent_i;
  logic [11:0] byte_allow_o;
  logic [2:0]  ingress_drop_i;
  egress_pace_pkg::port_tag_s [2:0] port_tag_o;
  int          bad_count;
  int          checked;
  int          cyc;

  egress_pace_vlan_drop_regs i_egress_pace_vlan_drop_regs
  (
    .clk_i, .rst_n_i, .ce_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .pace_global_en_i,
    .byte_sent_i, .byte_allow_o, .port_tag_o, .ingress_drop_i
  );

  // 100 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic final_report;
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // byte address of bank slot k: 0..5 pace, 6..8 tag, 9..11 drop, 12 unmapped
  function automatic logic [15:0] ba(input int k);
    return {egress_pace_pkg::IDX_PACE_P0_Q01 + 14'(k), 2'b00};
  endfunction

  // handshakes are judged at the falling edge, so the answer is never raced
  task automatic wr(input int k, input logic [31:0] d, input logic [1:0] er);
    logic [3:0] hs;
    logic [1:0] rs;
    s_axi_awaddr_i <= ba(k);
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    hs = 4'h0;
    while (!hs[3])
    begin
      @(negedge clk_i);
      hs = {s_axi_bvalid_o && s_axi_bready_i, s_axi_bvalid_o,
            s_axi_wvalid_i && s_axi_wready_o, s_axi_awvalid_i && s_axi_awready_o};
      rs = s_axi_bresp_o;
      @(posedge clk_i);
      if (hs[0])
        s_axi_awvalid_i <= 1'b0;
      if (hs[1])
        s_axi_wvalid_i <= 1'b0;
      s_axi_bready_i <= hs[2] && !hs[3]; // late ready makes the response stand
    end
    chk("bresp", {30'h0, er}, {30'h0, rs});
  endtask

  task automatic rd(input int k, input logic [31:0] ed, input logic [1:0] er);
    logic [2:0]  hs;
    logic [31:0] dat;
    logic [1:0]  rs;
    s_axi_araddr_i <= ba(k);
    s_axi_arvalid_i <= 1'b1;
    hs = 3'h0;
    while (!hs[2])
    begin
      @(negedge clk_i);
      hs = {s_axi_rvalid_o && s_axi_rready_i, s_axi_rvalid_o, s_axi_arvalid_i && s_axi_arready_o};
      dat = s_axi_rdata_o;
      rs = s_axi_rresp_o;
      @(posedge clk_i);
      if (hs[0])
        s_axi_arvalid_i <= 1'b0;
      s_axi_rready_i <= hs[1] && !hs[2];
    end
    chk("rdata", ed, dat);
    chk("rresp", {30'h0, er}, {30'h0, rs});
  endtask
////////////////////////////////////////
  // reset values of every register and of the tag outputs
  task automatic t_reset;
    for (int p = 0; p < 3; p++)
      chk("port_tag", 32'h0000_0001, 32'(port_tag_o[p]));
    for (int k = 0; k < 12; k++)
      rd(k, (k >= 6 && k < 9) ? 32'h0000_0001 : 32'h0000_0000, OK);
  endtask

  // all ones everywhere: reserved bits read zero, counters ignore writes
  task automatic t_regs;
    logic [31:0] e;
    for (int k = 0; k < 12; k++)
      wr(k, 32'hFFFF_FFFF, OK);
    for (int k = 0; k < 12; k++)
    begin
      e = k < 6 ? 32'h03FF_FFFF : (k < 9 ? 32'h0000_7FFF : 32'h0000_0000);
      rd(k, e, OK);
    end
    for (int p = 0; p < 3; p++)
    begin
      e = {17'h0, 3'(p + 5), 12'(12'hA5C + p)};
      wr(6 + p, e, OK);
      chk("port_tag", e, 32'(port_tag_o[p]));
    end
    wr(12, 32'h0000_1234, ERR);
    rd(12, 32'h0000_0000, ERR);
  endtask

  // per-port counts, clear on read, and a drop on the clearing edge
  task automatic t_drops;
    ingress_drop_i <= 3'b110;
    repeat (2) @(posedge clk_i);
    ingress_drop_i <= 3'b010;
    repeat (3) @(posedge clk_i);
    ingress_drop_i <= 3'b000;
    @(posedge clk_i);
    for (int p = 0; p < 3; p++)
    begin
      rd(9 + p, p == 1 ? 32'h0000_0005 : 32'(p), OK);
      rd(9 + p, 32'h0000_0000, OK);
    end
    ingress_drop_i <= 3'b001;
    fork
      rd(9, 32'h0000_0000, OK);
      begin
        @(posedge clk_i);
        ingress_drop_i <= 3'b000;
      end
    join
    rd(9, 32'h0000_0001, OK);
  endtask

  // queue 0 field 0 and queue 1 field 2, first enabled, then globally off
  task automatic t_pace;
    int lo [2];
    wr(0, {6'h0, 13'h0002, 13'h0000}, OK);
    for (int en = 1; en >= 0; en--)
    begin
      pace_global_en_i <= 1'(en);
      byte_sent_i <= 12'h003;
      @(posedge clk_i);
      byte_sent_i <= 12'h000;
      lo = '{0, 0};
      repeat (12)
      begin
        @(negedge clk_i);
        lo[0] += int'(byte_allow_o[0] === 1'b0);
        lo[1] += int'(byte_allow_o[1] === 1'b0);
      end
      @(posedge clk_i);
      chk("gap_q0", 32'(en * (CYC - 1)), 32'(lo[0]));
      chk("gap_q1", 32'(en * (3 * CYC - 1)), 32'(lo[1]));
    end
  endtask

  // clock enable low freezes the counters, so drops seen while frozen are lost
  task automatic t_freeze;
    ce_i <= 1'b0;
    ingress_drop_i <= 3'b111;
    repeat (2) @(posedge clk_i);
    ce_i <= 1'b1;
    ingress_drop_i <= 3'b000;
    for (int p = 0; p < 3; p++)
      rd(9 + p, 32'h0000_0000, OK);
  endtask
////////////////////////////////////////
  // a hang ends the run as a failure
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      final_report;
    end
  end

  initial
  begin
    bad_count = 0;
    checked = 0;
    cyc = 0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    s_axi_awaddr_i = 16'h0000;
    s_axi_awvalid_i = 1'b0;
    s_axi_wdata_i = 32'h0000_0000;
    s_axi_wstrb_i = 4'hF;
    s_axi_wvalid_i = 1'b0;
    s_axi_bready_i = 1'b0;
    s_axi_araddr_i = 16'h0000;
    s_axi_arvalid_i = 1'b0;
    s_axi_rready_i = 1'b0;
    pace_global_en_i = 1'b0;
    byte_sent_i = 12'h000;
    ingress_drop_i = 3'b000;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_regs;
    t_drops;
    t_pace;
    t_freeze;
    final_report;
  end
endmodule
`default_nettype wire
